// ==== pkg/snwp_pkg.sv ====
// Purpose: constants for the serial nvram status and write-protect block
// Assumes: spi mode 0 or 3, msb first, 21-bit array address
// Notes: status byte layout, opcodes, block-guard ranges
// What this block does
// - latch clear command clears write latch
// - bits 0,4,5 read zero, bit 6 one
// - bit 1 shows latch, zero after reset
// - status write data never loads latch flag
// - latch set only by set command, cleared by commands or reset
// - block guard bits at 2 and 3, kept
// - guard codes select none, quarter, half, all
// - array write needs latch and unguarded address
// - guard pin never affects array writes
// - bit 7 enables guard pin, else ignored
// - reject status write when enabled pin low
// - clear latch protects everything
// - status read shifts out status byte
// - bit 0 reads zero, never busy
// - delivered values zero, bit 6 one
// - latch set command sets write latch
// - chip select rise after writes clears latch
// - status write loads enable and guard bits
// - burst write stops at guarded address
package snwp_pkg;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam logic [7:0] OP_SS_WRITE = 8'h42;
  localparam logic [7:0] OP_SN_WRITE = 8'hC2;
  localparam int ST_BIT_LATCH = 1;
  localparam int ST_BIT_GUARD_LO = 2;
  localparam int ST_BIT_GUARD_HI = 3;
  localparam int ST_BIT_ONE = 6;
  localparam int ST_BIT_PIN_EN = 7;
  localparam int ADDR_W = 21;
  localparam logic [20:0] GUARD_QUARTER_BASE = 21'h180000;
  localparam logic [20:0] GUARD_HALF_BASE = 21'h100000;
  localparam logic [1:0] GUARD_RESET = 2'h0;
  localparam logic PIN_EN_RESET = 1'b0;
  localparam logic [7:0] ST_FIXED_ONES = 8'h40;
  // true when the address lies in the range the guard code selects
  function automatic logic snwp_guarded(input logic [1:0] code, input logic [20:0] addr);
    unique case (code)
      2'h0: snwp_guarded = 1'b0;
      2'h1: snwp_guarded = (addr >= GUARD_QUARTER_BASE);
      2'h2: snwp_guarded = (addr >= GUARD_HALF_BASE);
      2'h3: snwp_guarded = 1'b1;
    endcase
  endfunction
endpackage

// ==== src/snwp_nvbits.sv ====
// Purpose: retained protection bits, guard code and pin-guard enable
// Assumes: contents survive the functional reset, as a nonvolatile store would
// Notes: only the power-on load gives delivered values
`timescale 1ns/1ps
`default_nettype none
module snwp_nvbits (
  input wire logic clk_i,
  input wire logic por_i,
  input wire logic load_i,
  input wire logic [1:0] guard_i,
  input wire logic pin_en_i,
  output logic [1:0] guard_o,
  output logic pin_en_o
);
  // functional reset leaves these alone, so they persist across frames and resets
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      guard_o <= snwp_pkg::GUARD_RESET;
      pin_en_o <= snwp_pkg::PIN_EN_RESET;
    end else if (load_i) begin
      guard_o <= guard_i;
      pin_en_o <= pin_en_i;
    end
  end
endmodule // snwp_nvbits
`default_nettype wire

// ==== src/snwp_sync.sv ====
// Purpose: two-flop synchroniser for pin levels
// Assumes: asynchronous input, destination on SYS_CLK_I
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module snwp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_r <= INIT;
      q_o <= INIT;
    end else begin
      s1_r <= d_i;
      q_o <= s1_r;
    end
  end
endmodule // snwp_sync
`default_nettype wire

// ==== src/snwp_top.sv ====
// Purpose: status register, write latch and block protection of a serial nvram
// Assumes: spi pins oversampled on SYS_CLK_I, spi clock well below a quarter of it
// Notes: array data path lives outside; this block grants each byte write
`timescale 1ns/1ps
`default_nettype none
module snwp_top (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic POR_I,
  input wire logic CS_N_I,
  input wire logic SCK_I,
  input wire logic SI_I,
  input wire logic GUARD_N_I,
  output logic SO_O,
  output logic SO_OE_O,
  output logic [7:0] STATUS_O,
  output logic MEM_WR_O,
  output logic [20:0] MEM_ADDR_O,
  output logic [7:0] MEM_DATA_O
);
  typedef enum {S_IDLE, S_OP, S_ADDR, S_DATA, S_STREAD, S_STWR, S_IGNORE} snwp_state_t;
  snwp_state_t state_r;
  logic cs_n_s, sck_s, si_s, guard_n_s, sck_d_r, cs_d_r;
  logic mode3_r, latch_r, clr_on_rise_r, halted_r, st_load;
  logic [2:0] bit_cnt_r;
  logic [1:0] addr_cnt_r;
  logic [7:0] shift_r, status_w, st_shadow_r;
  logic [23:0] addr_r;
  logic [1:0] guard_w;
  logic pin_en_w;
  logic rise, fall, cs_fall, cs_rise, byte_done;
  logic [7:0] byte_w;

  snwp_sync #(.W(4), .INIT(4'hF)) u_sync (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .d_i({CS_N_I, SCK_I, SI_I, GUARD_N_I}),
    .q_o({cs_n_s, sck_s, si_s, guard_n_s})
  );

  snwp_nvbits u_nv (
    .clk_i(SYS_CLK_I),
    .por_i(POR_I),
    .load_i(st_load),
    .guard_i(byte_w[snwp_pkg::ST_BIT_GUARD_HI:snwp_pkg::ST_BIT_GUARD_LO]),
    .pin_en_i(byte_w[snwp_pkg::ST_BIT_PIN_EN]),
    .guard_o(guard_w),
    .pin_en_o(pin_en_w)
  );

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  assign cs_fall = cs_d_r && !cs_n_s;
  assign cs_rise = !cs_d_r && cs_n_s;
  assign rise = !cs_n_s && !cs_d_r && sck_s && !sck_d_r;
  assign fall = !cs_n_s && !cs_d_r && !sck_s && sck_d_r;
  assign byte_done = rise && (bit_cnt_r == 3'h7);
  assign byte_w = {shift_r[6:0], si_s};

  // fixed bits are not stored, so writes to them cannot take effect
  assign status_w = {pin_en_w, snwp_pkg::ST_FIXED_ONES[6:4], guard_w, latch_r, 1'b0};

  // status write accepted only with latch set and pin guard not active
  assign st_load = (state_r == S_STWR) && byte_done && latch_r
                   && !(pin_en_w && !guard_n_s);

  // mode 3 starts high; first rise after toggling is still a rise, so only record it
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      mode3_r <= 1'b0;
    end else if (cs_fall) begin
      mode3_r <= sck_s;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_r <= 3'h0;
    end else if (rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= byte_w;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_r <= S_IDLE;
      addr_cnt_r <= 2'h0;
    end else if (cs_n_s) begin
      state_r <= S_IDLE;
    end else if (cs_fall) begin
      state_r <= S_OP;
    end else if (byte_done) begin
      unique case (state_r)
        S_OP: begin
          addr_cnt_r <= 2'h0;
          unique case (byte_w)
            snwp_pkg::OP_STATUS_READ: state_r <= S_STREAD;
            snwp_pkg::OP_STATUS_WRITE: state_r <= S_STWR;
            snwp_pkg::OP_MEM_WRITE: state_r <= S_ADDR;
            default: state_r <= S_IGNORE;
          endcase
        end
        S_ADDR: begin
          addr_cnt_r <= addr_cnt_r + 2'h1;
          if (addr_cnt_r == 2'h2) begin
            state_r <= S_DATA;
          end
        end
        S_STWR: state_r <= S_IGNORE;
        S_IDLE, S_DATA, S_STREAD, S_IGNORE: state_r <= state_r;
      endcase
    end
  end

  // latch: set by set command, cleared by clear command or by cs rise after a write
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      latch_r <= 1'b0;
      clr_on_rise_r <= 1'b0;
    end else begin
      if (cs_rise && clr_on_rise_r) begin
        latch_r <= 1'b0;
      end else if ((state_r == S_OP) && byte_done && (byte_w == snwp_pkg::OP_LATCH_SET)) begin
        latch_r <= 1'b1;
      end
      if (cs_fall) begin
        clr_on_rise_r <= 1'b0;
      end else if ((state_r == S_OP) && byte_done) begin
        clr_on_rise_r <= (byte_w == snwp_pkg::OP_LATCH_CLEAR) || (byte_w == snwp_pkg::OP_STATUS_WRITE)
                         || (byte_w == snwp_pkg::OP_MEM_WRITE) || (byte_w == snwp_pkg::OP_SS_WRITE)
                         || (byte_w == snwp_pkg::OP_SN_WRITE);
      end
    end
  end

  // address capture and burst increment; halts at a guarded address until the next cs fall
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      addr_r <= 24'h000000;
      halted_r <= 1'b0;
    end else if (cs_fall) begin
      halted_r <= 1'b0;
    end else if (byte_done && (state_r == S_ADDR)) begin
      addr_r <= {addr_r[15:0], byte_w};
    end else if (byte_done && (state_r == S_DATA) && !halted_r) begin
      if (snwp_pkg::snwp_guarded(guard_w, addr_r[20:0])) begin
        halted_r <= 1'b1;
      end else begin
        addr_r <= {3'h0, addr_r[20:0] + 21'h000001};
      end
    end
  end

  // array byte grant ignores guard pin entirely
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      MEM_WR_O <= 1'b0;
      MEM_ADDR_O <= 21'h000000;
      MEM_DATA_O <= 8'h00;
    end else begin
      MEM_WR_O <= byte_done && (state_r == S_DATA) && !halted_r && latch_r
                  && !snwp_pkg::snwp_guarded(guard_w, addr_r[20:0]);
      if (byte_done && (state_r == S_DATA)) begin
        MEM_ADDR_O <= addr_r[20:0];
        MEM_DATA_O <= byte_w;
      end
    end
  end

  // status read: snapshot at opcode end, shift out msb first on falling edges
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      SO_O <= 1'b0;
      SO_OE_O <= 1'b0;
      st_shadow_r <= 8'h00;
    end else if (cs_n_s) begin
      SO_OE_O <= 1'b0;
    end else if ((state_r == S_OP) && byte_done && (byte_w == snwp_pkg::OP_STATUS_READ)) begin
      st_shadow_r <= status_w;
    end else if ((state_r == S_STREAD) && fall) begin
      SO_OE_O <= 1'b1;
      SO_O <= st_shadow_r[3'h7 - bit_cnt_r];
      if (bit_cnt_r == 3'h7) begin
        st_shadow_r <= status_w;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      STATUS_O <= snwp_pkg::ST_FIXED_ONES;
    end else begin
      STATUS_O <= status_w;
    end
  end

  AST_FIXED_BITS: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (status_w[0] == 1'b0) && (status_w[5:4] == 2'h0) && status_w[snwp_pkg::ST_BIT_ONE])
    else $error("fixed status bits wrong");
  AST_LATCH_SHOWN: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    STATUS_O[snwp_pkg::ST_BIT_LATCH] == $past(latch_r))
    else $error("status bit 1 not latch");
  AST_STWR_KEEPS_LATCH: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    st_load |=> latch_r)
    else $error("status write changed latch");
  AST_LATCH_SET: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    ((state_r == S_OP) && byte_done && (byte_w == snwp_pkg::OP_LATCH_SET) && !cs_rise) |=> latch_r)
    else $error("set command ignored");
  AST_CLEAR_ON_RISE: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (cs_rise && clr_on_rise_r) |=> !latch_r)
    else $error("latch not cleared at cs rise");
  AST_NO_WRITE_GUARDED: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    MEM_WR_O |-> !snwp_pkg::snwp_guarded(guard_w, MEM_ADDR_O) && $past(latch_r))
    else $error("write granted to guarded address");
  AST_PIN_REJECT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    ((state_r == S_STWR) && byte_done && pin_en_w && !guard_n_s) |=> $stable(guard_w))
    else $error("guarded status write accepted");
  AST_LATCH_CLEAR_PROT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    !latch_r |-> !st_load ##1 !MEM_WR_O)
    else $error("write with latch clear");
  AST_HALT_STOPS_ADDR: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (halted_r && !cs_fall) |=> $stable(addr_r) && !MEM_WR_O)
    else $error("burst moved past guarded address");
  AST_SO_ONLY_READ: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    SO_OE_O |-> $past(state_r == S_STREAD))
    else $error("output driven outside status read");
  COV_STREAD: cover property (@(posedge SYS_CLK_I) (state_r == S_STREAD) && byte_done);
  COV_STLOAD: cover property (@(posedge SYS_CLK_I) st_load);
  COV_HALT: cover property (@(posedge SYS_CLK_I) halted_r);
  COV_MEMWR: cover property (@(posedge SYS_CLK_I) MEM_WR_O);
  COV_MODE3_READ: cover property (@(posedge SYS_CLK_I) mode3_r && (state_r == S_STREAD) && byte_done);
endmodule // snwp_top
`default_nettype wire

// ==== tb/snwp_master.sv ====
// Purpose: spi bus master model, mode 0 or mode 3
// Assumes: sck half period of 10 system clocks
// Notes: si inverted after each frame so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module snwp_master (
  input wire logic clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  logic mode3 = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // idle clock level picks the mode the device sees at select
  task automatic set_mode(input logic m);
    tick(1);
    mode3 = m;
    sck_o = m;
    tick(20);
  endtask
  // r keeps the last byte shifted in
  task automatic frame(input logic [7:0] b[$], output logic [7:0] r);
    tick(1);
    cs_n_o = 1'b0;
    tick(10);
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sck_o = 1'b0;
        si_o = b[i][k];
        tick(10);
        sck_o = 1'b1;
        r = {r[6:0], so_i};
        tick(10);
      end
    end
    if (!mode3) begin
      sck_o = 1'b0;
    end
    tick(10);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick(20);
  endtask
endmodule // snwp_master
`default_nettype wire

// ==== tb/spi_nvram_status_write_protect_test.sv ====
// Purpose: self-checking bench for status and write-protect block
// Assumes: spi master model drives cs, sck and si
// Notes: grants counted from the byte-write pulse
`timescale 1ns/1ps
`default_nettype none
module spi_nvram_status_write_protect_test;
  logic clk = 1'b0;
  logic nrst_n = 1'b0;
  logic por = 1'b1;
  logic guard_n = 1'b1;
  logic cs_n, sck, si, so, so_oe, mem_wr;
  int oe_cnt = 0;
  logic [7:0] status, mem_data, r;
  logic [20:0] mem_addr, last_addr;
  int fails = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int c;
  always #4 clk = ~clk;
  snwp_top dut (.SYS_CLK_I(clk), .NRST_I(nrst_n), .POR_I(por), .CS_N_I(cs_n), .SCK_I(sck),
    .SI_I(si), .GUARD_N_I(guard_n), .SO_O(so), .SO_OE_O(so_oe), .STATUS_O(status),
    .MEM_WR_O(mem_wr), .MEM_ADDR_O(mem_addr), .MEM_DATA_O(mem_data));
  snwp_master m (.clk_i(clk), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  always @(posedge clk) begin
    if (so_oe === 1'b1) begin
      oe_cnt++;
    end
    if (mem_wr === 1'b1) begin
      wr_cnt++;
      last_addr = mem_addr;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [7:0] exp);
    int oe0;
    oe0 = oe_cnt;
    chk(status, exp);
    m.frame('{8'h05, 8'h00}, r);
    chk(r, exp);
    chk(oe_cnt != oe0, 1);
    chk(so_oe, 0);
  endtask
  task automatic t_mode3();
    m.set_mode(1'b1);
    st(8'h40);
    m.frame('{8'h06}, r);
    st(8'h42);
    m.frame('{8'h04}, r);
    st(8'h40);
    m.set_mode(1'b0);
  endtask
  // latch set frame always precedes the write
  task automatic status_write_cmd(input logic [7:0] v);
    m.frame('{8'h06}, r);
    m.frame('{8'h01, v}, r);
  endtask
  task automatic mw(input logic [20:0] a);
    m.frame('{8'h06}, r);
    m.frame('{8'h02, {3'h0, a[20:16]}, a[15:8], a[7:0], 8'hAA, 8'hBB}, r);
  endtask
  task automatic t_latch();
    st(8'h40);
    m.frame('{8'h06}, r);
    st(8'h42);
    m.frame('{8'h04}, r);
    st(8'h40);
  endtask
  task automatic t_status();
    m.frame('{8'h01, 8'h0C}, r);
    st(8'h40);
    status_write_cmd(8'hFF);
    st(8'hCC);
    guard_n = 1'b0;
    status_write_cmd(8'h00);
    st(8'hCC);
    guard_n = 1'b1;
    status_write_cmd(8'h80);
    guard_n = 1'b0;
    c = wr_cnt;
    mw(21'h000010);
    chk(wr_cnt - c, 2);
    chk(mem_data, 8'hBB);
    chk(last_addr, 21'h000011);
    guard_n = 1'b1;
    status_write_cmd(8'h00);
    guard_n = 1'b0;
    status_write_cmd(8'h04);
    st(8'h44);
    guard_n = 1'b1;
  endtask
  task automatic t_mem();
    int exp;
    for (int k = 0; k < 4; k++) begin
      status_write_cmd({4'h0, k[1:0], 2'h0});
      exp = (k == 0) ? 2 : (k == 1) ? 1 : 0;
      c = wr_cnt;
      mw(21'h17FFFF);
      chk(wr_cnt - c, exp);
      chk(status, 8'h40 | (k << 2));
    end
    chk(last_addr, 21'h17FFFF);
    status_write_cmd(8'h00);
    c = wr_cnt;
    m.frame('{8'h02, 8'h00, 8'h00, 8'h20, 8'h55}, r);
    chk(wr_cnt - c, 0);
  endtask
  task automatic t_keep();
    status_write_cmd(8'h88);
    m.frame('{8'h06}, r);
    @(negedge clk);
    nrst_n = 1'b0;
    m.tick(5);
    nrst_n = 1'b1;
    m.tick(5);
    st(8'hC8);
    status_write_cmd(8'h00);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    m.tick(2);
    por = 1'b0;
    m.tick(3);
    nrst_n = 1'b1;
    m.tick(5);
    t_latch();
    t_mode3();
    t_status();
    t_mem();
    t_keep();
    finish_test();
  end
  // tests need about 19k cycles
  initial begin
    #480000;
    fails++;
    finish_test();
  end
endmodule // spi_nvram_status_write_protect_test
`default_nettype wire
